// ### timebase_pkg.sv
/*
 Constants shared by the acquisition time base and its trigger qualifier.
 Assumes a single 50 MHz core clock that stands in for the reference clock.
*/
package timebase_pkg;
    localparam int unsigned CLK_MHZ         = 50;
    localparam int unsigned REF_MHZ         = 100;
    localparam int unsigned DLY_MIN_PS      = 1500;
    localparam int unsigned DLY_MAX_PS      = 20000;
    localparam int unsigned CLK_PERIOD_PS   = 1000000 / CLK_MHZ;
    localparam int unsigned DLY_MIN_CYC     = (DLY_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned DLY_MAX_CYC_RAW = DLY_MAX_PS / CLK_PERIOD_PS;
    localparam int unsigned DLY_MAX_CYC     = (DLY_MAX_CYC_RAW < 1) ? 1 : DLY_MAX_CYC_RAW;
    localparam int unsigned STRETCH_FACTOR  = 1000;
    localparam logic [1:0]  MODE_INPHASE    = 2'h0;
    localparam logic [1:0]  MODE_INTERLEAVE = 2'h1;
    localparam logic [1:0]  MODE_DOUBLED    = 2'h2;
    localparam logic [3:0]  CHAN_ALL        = 4'hf;
    localparam logic [3:0]  CHAN_ONE_THREE  = 4'h5;
    localparam logic [1:0]  PHASE_90        = 2'h1;
    localparam logic [1:0]  PHASE_180       = 2'h2;
    localparam logic [1:0]  PHASE_0         = 2'h0;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_PRE  = 5'b00010,
        ST_ARM  = 5'b00100,
        ST_POST = 5'b01000,
        ST_DONE = 5'b10000
    } acq_state_t;
endpackage

// ### trig_qualifier.sv
/*
 Logic trigger qualifier: holdoff, delay and pattern duration/range checks.
 Assumes the channel trigger input is already synchronised to core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module trig_qualifier
    import timebase_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic         chan_trig,
    input  wire logic [W-1:0] holdoff_cyc,
    input  wire logic [W-1:0] delay_cyc,
    input  wire logic [W-1:0] dur_min_cyc,
    input  wire logic [W-1:0] dur_max_cyc,
    input  wire logic         enable,
    output logic              trig_out
);
    logic [W-1:0] dur_q;
    logic [W-1:0] hold_q;
    logic [W-1:0] dly_q;
    logic         prev_q;
    logic         dly_run_q;
    logic         trig_q;
    wire          fall      = prev_q & ~chan_trig;
    wire          in_range  = (dur_q >= dur_min_cyc) && (dur_q <= dur_max_cyc);
    wire          qualified = enable & fall & in_range & (hold_q == '0) & ~dly_run_q;
    wire          dly_done  = dly_run_q & (dly_q == '0);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dur_q     <= '0;
            hold_q    <= '0;
            dly_q     <= '0;
            prev_q    <= 1'b0;
            dly_run_q <= 1'b0;
            trig_q    <= 1'b0;
        end else begin
            prev_q <= chan_trig;
            dur_q  <= chan_trig ? ((dur_q == '1) ? dur_q : dur_q + 1'b1) : '0;
            if (qualified) begin
                dly_run_q <= 1'b1;
                dly_q     <= delay_cyc;
            end else if (dly_done) begin
                dly_run_q <= 1'b0;
            end else if (dly_run_q) begin
                dly_q <= dly_q - 1'b1;
            end
            if (dly_done) begin
                hold_q <= holdoff_cyc;
            end else if (hold_q != '0) begin
                hold_q <= hold_q - 1'b1;
            end
            trig_q <= dly_done;
        end
    end
    assign trig_out = trig_q;

    a_holdoff_blocks: assert property (@(posedge core_clk) disable iff (!rstn)
        (hold_q != '0) |-> !qualified) else $error("Trigger qualified during holdoff.");
    a_delay_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
        dly_done |=> trig_out ##1 !trig_out) else $error("Delayed trigger pulse wrong.");
    a_holdoff_load: assert property (@(posedge core_clk) disable iff (!rstn)
        trig_out |-> hold_q == $past(holdoff_cyc))
        else $error("Holdoff not started with trigger.");
endmodule // trig_qualifier
`default_nettype wire

// ### acq_timebase.sv
/*
 Acquisition time base: sample divider, decimation, converter mode control,
 pre/post trigger sequencing and trigger interpolator counting.
 Assumes pins from the trigger multiplexer and stretcher are asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module acq_timebase
    import timebase_pkg::*;
#(
    parameter int CW = 16,
    parameter int QW = 16
) (
    input  wire logic          core_clk,
    input  wire logic          rstn,
    input  wire logic          start,
    input  wire logic [CW-1:0] rate_div,
    input  wire logic [CW-1:0] decim,
    input  wire logic [1:0]    conv_mode,
    input  wire logic [CW-1:0] pre_count,
    input  wire logic [CW-1:0] post_count,
    input  wire logic          qualified_trigger,
    input  wire logic          stretch_done,
    input  wire logic          chan_trig,
    input  wire logic [QW-1:0] holdoff_cyc,
    input  wire logic [QW-1:0] delay_cyc,
    input  wire logic [QW-1:0] dur_min_cyc,
    input  wire logic [QW-1:0] dur_max_cyc,
    output logic               sample_clk_en,
    output logic               sample_keep,
    output logic [3:0]         chan_enable,
    output logic [1:0]         pair_phase,
    output logic               pretrig_ready,
    output logic               acq_complete,
    output logic               interp_pulse,
    output logic [CW-1:0]      interp_count,
    output logic               interp_valid,
    output logic               logic_trig
);
    acq_state_t state_q;
    acq_state_t state_d;
    logic [CW-1:0] div_q;
    logic [CW-1:0] dec_q;
    logic [CW-1:0] pre_q;
    logic [CW-1:0] post_q;
    logic [CW-1:0] icnt_q;
    logic [CW-1:0] icnt_out_q;
    logic          ivalid_q;
    logic          ipulse_q;
    logic          icount_run_q;
    logic [1:0]    mode_q;
    logic [1:0]    trg_s;
    logic [1:0]    str_s;
    logic [1:0]    ct_s;
    logic          trg_prev_q;
    logic          str_prev_q;

    // Pin inputs pass two flip-flops before use.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            trg_s <= 2'h0;
            str_s <= 2'h0;
            ct_s  <= 2'h0;
        end else begin
            trg_s <= {trg_s[0], qualified_trigger};
            str_s <= {str_s[0], stretch_done};
            ct_s  <= {ct_s[0], chan_trig};
        end
    end

    wire running    = (state_q == ST_PRE) || (state_q == ST_ARM) || (state_q == ST_POST);
    wire div_tick   = running && (div_q == '0);
    wire dec_tick   = div_tick && (dec_q == '0);
    wire trg_rise   = trg_s[1] & ~trg_prev_q;
    wire str_rise   = str_s[1] & ~str_prev_q;
    wire take_trig  = (state_q == ST_ARM) && trg_rise;
    wire pre_full   = (pre_q == '0);
    wire post_zero  = (post_q == '0);
    wire store_cnt  = icount_run_q && str_rise;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (start) state_d = ST_PRE;
            ST_PRE:  if (pre_full) state_d = ST_ARM;
            ST_ARM:  if (take_trig) state_d = ST_POST;
            ST_POST: if (post_zero && dec_tick) state_d = ST_DONE;
            ST_DONE: if (start) state_d = ST_PRE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q    <= ST_IDLE;
            div_q      <= '0;
            dec_q      <= '0;
            pre_q      <= '0;
            post_q     <= '0;
            mode_q     <= MODE_INPHASE;
            trg_prev_q <= 1'b0;
            str_prev_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            trg_prev_q <= trg_s[1];
            str_prev_q <= str_s[1];
            div_q      <= (!running || div_q == '0) ? rate_div : div_q - 1'b1;
            if (!running) begin
                dec_q <= decim;
            end else if (div_tick) begin
                dec_q <= (dec_q == '0) ? decim : dec_q - 1'b1;
            end
            if (start && !running) begin
                pre_q  <= pre_count;
                post_q <= post_count;
                mode_q <= conv_mode;
            end else begin
                if (state_q == ST_PRE && dec_tick && !pre_full) pre_q <= pre_q - 1'b1;
                if (state_q == ST_POST && dec_tick && !post_zero) post_q <= post_q - 1'b1;
            end
        end
    end

    // Interpolator pulse and stretched-interval counter.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ipulse_q     <= 1'b0;
            icount_run_q <= 1'b0;
            icnt_q       <= '0;
            icnt_out_q   <= '0;
            ivalid_q     <= 1'b0;
        end else begin
            if (take_trig) ipulse_q <= 1'b1;
            else if (div_tick) ipulse_q <= 1'b0;
            if (take_trig) begin
                icount_run_q <= 1'b1;
                icnt_q       <= '0;
                ivalid_q     <= 1'b0;
            end else if (icount_run_q && str_rise) begin
                icount_run_q <= 1'b0;
                icnt_out_q   <= icnt_q;
                ivalid_q     <= 1'b1;
            end else if (icount_run_q && div_tick) begin
                icnt_q <= icnt_q + 1'b1;
            end
            if (start && !running && !store_cnt) ivalid_q <= 1'b0;
        end
    end

    assign sample_clk_en = div_tick;
    assign sample_keep   = dec_tick;
    assign pretrig_ready = (state_q == ST_ARM);
    assign acq_complete  = (state_q == ST_DONE);
    assign interp_pulse  = ipulse_q;
    assign interp_count  = icnt_out_q;
    assign interp_valid  = ivalid_q;
    assign chan_enable   = (mode_q == MODE_DOUBLED) ? CHAN_ONE_THREE : CHAN_ALL;
    assign pair_phase    = (mode_q == MODE_DOUBLED) ? PHASE_90 :
                           (mode_q == MODE_INTERLEAVE) ? PHASE_180 : PHASE_0;

    trig_qualifier #(.W(QW)) u_qual (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .chan_trig   (ct_s[1]),
        .holdoff_cyc (holdoff_cyc),
        .delay_cyc   (delay_cyc),
        .dur_min_cyc (dur_min_cyc),
        .dur_max_cyc (dur_max_cyc),
        .enable      (1'b1),
        .trig_out    (logic_trig)
    );

    sequence s_armed;
        pretrig_ready && trg_rise;
    endsequence
    sequence s_post;
        !pretrig_ready && !acq_complete;
    endsequence

    a_ready_needs_pre: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(pretrig_ready) |-> $past(pre_q) == '0) else $error("Ready before pre-trigger count.");
    a_trig_starts_post: assert property (@(posedge core_clk) disable iff (!rstn)
        s_armed |=> s_post) else $error("Trigger did not start countdown.");
    a_done_stops_clk: assert property (@(posedge core_clk) disable iff (!rstn)
        acq_complete |-> !sample_clk_en) else $error("Sample clock runs after completion.");
    a_done_holds: assert property (@(posedge core_clk) disable iff (!rstn)
        acq_complete && !start |=> acq_complete && !pretrig_ready) else $error("Completion not held.");
    a_pulse_on_trig: assert property (@(posedge core_clk) disable iff (!rstn)
        take_trig |=> interp_pulse) else $error("Interpolator pulse missing.");
    a_pulse_ends_tick: assert property (@(posedge core_clk) disable iff (!rstn)
        interp_pulse && div_tick && !take_trig |=> !interp_pulse) else $error("Pulse outlived sample edge.");
    a_count_stored: assert property (@(posedge core_clk) disable iff (!rstn)
        icount_run_q && str_rise && !take_trig |=> interp_valid && interp_count == $past(icnt_q))
        else $error("Interpolator count not stored.");
    a_doubled_chans: assert property (@(posedge core_clk) disable iff (!rstn)
        mode_q == MODE_DOUBLED |-> chan_enable == CHAN_ONE_THREE && pair_phase == PHASE_90)
        else $error("Doubled mode channel map wrong.");
    a_decim_subset: assert property (@(posedge core_clk) disable iff (!rstn)
        sample_keep |-> sample_clk_en) else $error("Kept sample without sample tick.");

    // Counter steps, divider reload and refusal after completion.
    a_div_reload: assert property (@(posedge core_clk) disable iff (!rstn)
        div_tick |=> div_q == $past(rate_div))
        else $error("Divider did not reload.");
    a_pre_steps: assert property (@(posedge core_clk) disable iff (!rstn)
        state_q == ST_PRE && dec_tick && !pre_full |=> pre_q == $past(pre_q) - 1'b1)
        else $error("Pre-trigger count did not step.");
    a_post_steps: assert property (@(posedge core_clk) disable iff (!rstn)
        state_q == ST_POST && dec_tick && !post_zero |=> post_q == $past(post_q) - 1'b1)
        else $error("Post-trigger count did not step.");
    a_zero_completes: assert property (@(posedge core_clk) disable iff (!rstn)
        state_q == ST_POST && post_zero && dec_tick |=> acq_complete)
        else $error("Countdown end did not complete.");
    a_count_advances: assert property (@(posedge core_clk) disable iff (!rstn)
        icount_run_q && div_tick && !str_rise && !take_trig |=> icnt_q == $past(icnt_q) + 1'b1)
        else $error("Interpolator counter did not advance.");
    a_pulse_needs_trig: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(interp_pulse) |-> $past(take_trig))
        else $error("Interpolator pulse without trigger.");
    a_done_refuses: assert property (@(posedge core_clk) disable iff (!rstn)
        acq_complete && trg_rise && !start |=> acq_complete && !interp_pulse)
        else $error("Trigger taken after completion.");
endmodule // acq_timebase
`default_nettype wire

// ### trig_partner.sv
/*
 Far-side model: trigger multiplexer returning the qualified trigger, and the
 interpolator pulse stretcher reporting completion.
 Assumes one core clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none
module trig_partner #(
    parameter int TRIG_WAIT    = 5,
    parameter int STRETCH_WAIT = 30
) (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic pretrig_ready,
    input  wire logic interp_pulse,
    output logic      qualified_trigger,
    output logic      stretch_done
);
    int   tcnt_q;
    int   scnt_q;
    logic pulse_q;
    wire logic pulse_fell = pulse_q & ~interp_pulse;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tcnt_q            <= 0;
            scnt_q            <= 0;
            pulse_q           <= 1'b0;
            qualified_trigger <= 1'b0;
            stretch_done      <= 1'b0;
        end else begin
            pulse_q           <= interp_pulse;
            tcnt_q            <= pretrig_ready ? tcnt_q + 1 : 0;
            qualified_trigger <= pretrig_ready && (tcnt_q >= TRIG_WAIT);
            scnt_q            <= pulse_fell ? 1 : (scnt_q == STRETCH_WAIT + 4) ? 0 : (scnt_q != 0) ? scnt_q + 1 : 0;
            stretch_done      <= (scnt_q >= STRETCH_WAIT) && (scnt_q < STRETCH_WAIT + 4);
        end
    end
endmodule // trig_partner
`default_nettype wire

// ### tb_acq_timebase.sv
/*
 Self-checking testbench for the acquisition time base.
 Assumes the partner model answers triggers and stretches; 50 MHz core clock.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_acq_timebase;
    import timebase_pkg::*;
    localparam int CW = 16;
    logic          core_clk, rstn, start, chan_trig, stray, ptrig, stretch_done;
    logic [CW-1:0] rate_div, decim, pre_count, post_count, holdoff_cyc, delay_cyc, dur_min_cyc, dur_max_cyc;
    logic [1:0]    conv_mode, pair_phase;
    logic [3:0]    chan_enable;
    logic [CW-1:0] interp_count;
    logic          sample_clk_en, sample_keep, pretrig_ready, acq_complete, interp_pulse, interp_valid, logic_trig;
    wire logic     qualified_trigger = ptrig | stray;
    int            err_total, num_checks;

    acq_timebase #(.CW(CW), .QW(CW)) u_acq_timebase (.core_clk(core_clk), .rstn(rstn), .start(start),
        .rate_div(rate_div), .decim(decim), .conv_mode(conv_mode), .pre_count(pre_count),
        .post_count(post_count), .qualified_trigger(qualified_trigger), .stretch_done(stretch_done),
        .chan_trig(chan_trig), .holdoff_cyc(holdoff_cyc), .delay_cyc(delay_cyc), .dur_min_cyc(dur_min_cyc),
        .dur_max_cyc(dur_max_cyc), .sample_clk_en(sample_clk_en), .sample_keep(sample_keep),
        .chan_enable(chan_enable), .pair_phase(pair_phase), .pretrig_ready(pretrig_ready),
        .acq_complete(acq_complete), .interp_pulse(interp_pulse), .interp_count(interp_count),
        .interp_valid(interp_valid), .logic_trig(logic_trig));
    trig_partner u_trig_partner (.core_clk(core_clk), .rstn(rstn), .pretrig_ready(pretrig_ready),
        .interp_pulse(interp_pulse), .qualified_trigger(ptrig), .stretch_done(stretch_done));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // One acquisition with a stray trigger in the pre-trigger phase and another after completion.
    task automatic acquire(input logic [1:0] mode, input logic [CW-1:0] pre, input logic [CW-1:0] post);
        int c, last, n, k, w;
        logic seen_keep;
        @(posedge core_clk);
        conv_mode <= mode; pre_count <= pre; post_count <= post; start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        c = 0; last = -1; n = 0; k = 0; seen_keep = 1'b0;
        while (pretrig_ready !== 1'b1 && c < 5000) begin
            @(posedge core_clk);
            stray <= (c >= 2 && c < 5);
            @(negedge core_clk);
            c++;
            if (sample_clk_en === 1'b1) begin
                if (last >= 0) check(c - last, rate_div + 1);
                last = c; n++;
            end
            if (sample_keep === 1'b1) begin
                if (seen_keep) check(n, decim + 1);
                n = 0; seen_keep = 1'b1; k++;
            end
        end
        check(pretrig_ready, 1'b1);
        check(k >= pre && k <= pre + 1, 1'b1);
        check(chan_enable, (mode == MODE_DOUBLED) ? CHAN_ONE_THREE : CHAN_ALL);
        check(pair_phase, (mode == MODE_DOUBLED) ? PHASE_90 : (mode == MODE_INTERLEAVE) ? PHASE_180 : PHASE_0);
        c = 0; k = 0; w = 0;
        while (acq_complete !== 1'b1 && c < 5000) begin
            @(negedge core_clk);
            c++;
            if (interp_pulse === 1'b1) w++;
            if (sample_keep === 1'b1 && pretrig_ready === 1'b0) k++;
        end
        check(acq_complete, 1'b1);
        check(w >= 1 && w <= rate_div + 1, 1'b1);
        check(k >= post && k <= post + 1, 1'b1);
        c = 0; k = 0;
        repeat (60) begin
            @(posedge core_clk);
            stray <= (c >= 5 && c < 12);
            @(negedge core_clk);
            c++;
            if (sample_clk_en === 1'b1 || pretrig_ready === 1'b1 || acq_complete !== 1'b1) k++;
        end
        check(k, 0);
        check(interp_valid, 1'b1);
        check(interp_count != '0, 1'b1);
        check(pretrig_ready, 1'b0);
    endtask

    // One channel trigger pulse of the given width; the qualifier fires or not.
    task automatic qualify(input int width, input logic exp);
        logic fired;
        int   i, lat;
        fired = 1'b0; i = 0; lat = 0;
        @(posedge core_clk);
        chan_trig <= 1'b1;
        repeat (width) @(posedge core_clk);
        chan_trig <= 1'b0;
        repeat (60) begin
            @(negedge core_clk);
            i++;
            if (logic_trig === 1'b1 && !fired) lat = i;
            if (logic_trig === 1'b1) fired = 1'b1;
        end
        check(fired, exp);
        // Two synchroniser stages, edge detect, the delay count and the output register.
        if (exp) check(lat, delay_cyc + 5);
    endtask

    // Two qualifying pulses one cycle apart; holdoff lets only the first through.
    task automatic holdoff_pair();
        int hits;
        hits = 0;
        @(posedge core_clk);
        for (int i = 0; i < 72; i++) begin
            chan_trig <= (i < 5) || (i >= 6 && i < 11);
            @(negedge core_clk);
            if (logic_trig === 1'b1) hits++;
            @(posedge core_clk);
        end
        check(hits, 1);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        #200000;
        err_total++;
        end_sim();
    end

    initial begin
        err_total = 0; num_checks = 0;
        rstn = 1'b0; start = 1'b0; chan_trig = 1'b0; stray = 1'b0; conv_mode = MODE_INPHASE;
        rate_div = 16'h0003; decim = 16'h0002; pre_count = 16'h0004; post_count = 16'h0005;
        holdoff_cyc = 16'h0004; delay_cyc = 16'h0002; dur_min_cyc = 16'h0003; dur_max_cyc = 16'h000a;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        @(negedge core_clk);
        check({pretrig_ready, acq_complete, interp_valid, logic_trig, sample_clk_en}, 5'h00);
        check(chan_enable, CHAN_ALL);
        acquire(MODE_INPHASE, 16'h0004, 16'h0005);
        @(posedge core_clk);
        rate_div <= 16'h0001;
        decim <= 16'h0000;
        acquire(MODE_INTERLEAVE, 16'h0006, 16'h0001);
        acquire(MODE_DOUBLED, 16'h0003, 16'h0008);
        qualify(5, 1'b1);
        qualify(2, 1'b0);
        qualify(15, 1'b0);
        holdoff_pair();
        end_sim();
    end
endmodule // tb_acq_timebase
`default_nettype wire
